// [lgt_blocks.sv]
// lgt_blocks: scan-evaluated gate library with one on-delay and one off-delay timer
// assumes all inputs synchronous to mclk_i; setpoints held steady by configuration
// Functional notes
// - edge-qualified AND high when all inputs high and one was low last scan
// - OR high when any of eight inputs is high
// - NOT output is the inverse of its input
// - XOR high when its two inputs differ
// - NAND low only when all eight inputs are high
// - edge-qualified NAND high when one input low and all were high last scan
// - NOR high only when every input is low
// - rising-edge OR high when any input rose since last scan
// - falling-edge OR high when any input fell since last scan
// - on-delay starts on trigger rise, output high after setpoint if trigger held
// - on-delay clears elapsed time if trigger drops before setpoint
// - on-delay output low whenever trigger is low
// - on-delay reset clears time and output, overriding trigger
// - setpoint in h:m:s.ms, 10 ms up to 999:59:59.990
// - on-delay timing within 5 ms of setpoint
// - each timer shows its running value on a data output
// - optional retentive mode keeps timer state over reset
// - off-delay output high at once while trigger high
// - off-delay times after trigger falls, then output low and clears
// - each new trigger fall restarts off-delay timing from zero
// - off-delay reset clears time and output, overriding trigger
// - off-delay expiry within 5 ms of setpoint
// - all blocks evaluated once per scan, previous values from preceding scan
`timescale 1ns/100ps
module lgt_blocks #(
   parameter int TICK_CYC = lgt_pkg::LGT_TICK_CYC, // cycles per 10 ms tick
   parameter int SCAN_CYC = lgt_pkg::LGT_SCAN_CYC  // cycles per scan
) (
   input  wire logic                       mclk_i,     // system clock
   input  wire logic                       rst_i,      // sync reset
   input  wire lgt_pkg::lgt_gin_t          gate_i,     // gate inputs
   output lgt_pkg::lgt_gout_t              gate_o,     // gate outputs
   input  wire logic                       on_trg_i,   // on-delay trigger
   input  wire logic                       on_rst_i,   // on-delay reset
   input  wire lgt_pkg::lgt_tcfg_t         on_cfg_i,   // on-delay config
   output logic                            on_q_o,     // on-delay output
   output logic      [lgt_pkg::LGT_TW-1:0] on_run_o,   // on-delay running value
   input  wire logic                       off_trg_i,  // off-delay trigger
   input  wire logic                       off_rst_i,  // off-delay reset
   input  wire lgt_pkg::lgt_tcfg_t         off_cfg_i,  // off-delay config
   output logic                            off_q_o,    // off-delay output
   output logic      [lgt_pkg::LGT_TW-1:0] off_run_o   // off-delay running value
);
   import lgt_pkg::*;

   typedef struct packed {
      logic [31:0]         tick_cnt;
      logic [31:0]         scan_cnt;
      logic [LGT_IN_W-1:0] prev_andl;
      logic [LGT_IN_W-1:0] prev_nandl;
      logic [LGT_IN_W-1:0] prev_orr;
      logic [LGT_IN_W-1:0] prev_orf;
      lgt_gout_t           gout;
      logic [LGT_TW-1:0]   on_setp;
      logic [LGT_TW-1:0]   off_setp;
   } lgt_st_t;

   lgt_st_t          s_reg;
   lgt_st_t          s_next;
   logic             scan_en;
   logic             tick;
   logic             half;
   logic [LGT_TW-1:0] on_ticks;
   logic [LGT_TW-1:0] off_ticks;

   // =========================================================
   // setpoint conversion
   // fields beyond their range saturate rather than wrap, so a bad
   // field gives its own longest legal value, never a short one
   function automatic logic [LGT_TW-1:0] to_ticks(input lgt_setp_t sp);
      logic [LGT_TW-1:0] h;
      logic [LGT_TW-1:0] m;
      logic [LGT_TW-1:0] sc;
      logic [LGT_TW-1:0] ms;
      logic [LGT_TW-1:0] t;
      h  = (sp.hours   > 10'(LGT_HOUR_MAX)) ? LGT_TW'(LGT_HOUR_MAX) : LGT_TW'(sp.hours);
      m  = (sp.minutes > 6'(LGT_MIN_MAX))   ? LGT_TW'(LGT_MIN_MAX)  : LGT_TW'(sp.minutes);
      sc = (sp.seconds > 6'(LGT_SEC_MAX))   ? LGT_TW'(LGT_SEC_MAX)  : LGT_TW'(sp.seconds);
      ms = (sp.millis  > 10'(LGT_MS_MAX))   ? LGT_TW'(LGT_MS_MAX)   : LGT_TW'(sp.millis);
      t  = h * LGT_TW'(LGT_TICK_HOUR) + m * LGT_TW'(LGT_TICK_MIN)
         + sc * LGT_TW'(LGT_TICK_SEC) + ms / LGT_TW'(LGT_TICK_MS);
      if (t == '0) begin
         t = LGT_TW'(LGT_MS_MIN / LGT_TICK_MS);
      end
      return t;
   endfunction : to_ticks

   assign on_ticks  = to_ticks(on_cfg_i.setp);
   assign off_ticks = to_ticks(off_cfg_i.setp);

   // =========================================================
   // strobes from the dividers
   assign tick    = (s_reg.tick_cnt == 32'(TICK_CYC - 1));
   // a tick on this very edge leaves a whole period ahead, so it is not a late phase
   assign half    = (s_reg.tick_cnt >= 32'(TICK_CYC / 2)) && !tick;
   assign scan_en = (s_reg.scan_cnt == 32'(SCAN_CYC - 1));

   // =========================================================
   // one scan: every block reads this scan's inputs, the edge blocks also last scan's copy
   always_comb begin
      s_next          = s_reg;
      s_next.tick_cnt = tick ? 32'h0 : s_reg.tick_cnt + 32'h1;
      s_next.scan_cnt = scan_en ? 32'h0 : s_reg.scan_cnt + 32'h1;
      s_next.on_setp  = on_ticks;
      s_next.off_setp = off_ticks;
      if (scan_en) begin
         s_next.gout.and_q   = &gate_i.and8;
         s_next.gout.andl_q  = (&gate_i.andl8) && !(&s_reg.prev_andl);
         s_next.gout.or_q    = |gate_i.or8;
         s_next.gout.not_q   = !gate_i.not1;
         s_next.gout.xor_q   = gate_i.xor2[0] ^ gate_i.xor2[1];
         s_next.gout.nand_q  = !(&gate_i.nand8);
         s_next.gout.nandl_q = !(&gate_i.nandl8) && (&s_reg.prev_nandl);
         s_next.gout.nor_q   = !(|gate_i.nor8);
         s_next.gout.orr_q   = |(gate_i.orr8 & ~s_reg.prev_orr);
         s_next.gout.orf_q   = |(~gate_i.orf8 & s_reg.prev_orf);
         // previous-scan copies, kept only for the edge blocks
         s_next.prev_andl    = gate_i.andl8;
         s_next.prev_nandl   = gate_i.nandl8;
         s_next.prev_orr     = gate_i.orr8;
         s_next.prev_orf     = gate_i.orf8;
      end
   end

   // =========================================================
   // state register
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         s_reg            <= '0;
         s_reg.prev_andl  <= LGT_PREV_RST;
         s_reg.prev_nandl <= LGT_PREV_RST;
         s_reg.prev_orr   <= LGT_PREV_RST;
         s_reg.prev_orf   <= LGT_PREV_RST;
         // reload at once, so a timer retained through reset never sees a short setpoint
         s_reg.on_setp    <= on_ticks;
         s_reg.off_setp   <= off_ticks;
      end else begin
         s_reg <= s_next;
      end
   end
   assign gate_o = s_reg.gout;

   // =========================================================
   // timers
   lgt_timer #(
      .OFF_DELAY (1'b0)
   ) u_on_delay_timer (
      .mclk_i    (mclk_i),
      .rst_i     (rst_i),
      .scan_en_i (scan_en),
      .tick_i    (tick),
      .half_i    (half),
      .trg_i     (on_trg_i),
      .trst_i    (on_rst_i),
      .retain_i  (on_cfg_i.retain),
      .setp_i    (s_reg.on_setp),
      .q_o       (on_q_o),
      .run_o     (on_run_o)
   );

   lgt_timer #(
      .OFF_DELAY (1'b1)
   ) u_off_delay_timer (
      .mclk_i    (mclk_i),
      .rst_i     (rst_i),
      .scan_en_i (scan_en),
      .tick_i    (tick),
      .half_i    (half),
      .trg_i     (off_trg_i),
      .trst_i    (off_rst_i),
      .retain_i  (off_cfg_i.retain),
      .setp_i    (s_reg.off_setp),
      .q_o       (off_q_o),
      .run_o     (off_run_o)
   );

   // =========================================================
   // checks
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);

   chk_andl_edge: assert property (scan_en |=> gate_o.andl_q ==
      ((&$past(gate_i.andl8)) && !(&$past(s_reg.prev_andl))))
      else $error("edge AND wrong");
   chk_or_any: assert property (scan_en |=> gate_o.or_q == (|$past(gate_i.or8)))
      else $error("OR wrong");
   chk_not_inv: assert property (scan_en |=> gate_o.not_q != $past(gate_i.not1))
      else $error("NOT wrong");
   chk_xor_diff: assert property (scan_en |=> gate_o.xor_q ==
      ($past(gate_i.xor2[0]) != $past(gate_i.xor2[1]))) else $error("XOR wrong");
   chk_nand_all: assert property (scan_en |=> gate_o.nand_q ==
      !(&$past(gate_i.nand8))) else $error("NAND wrong");
   chk_nandl_edge: assert property (scan_en |=> gate_o.nandl_q ==
      (!(&$past(gate_i.nandl8)) && (&$past(s_reg.prev_nandl))))
      else $error("edge NAND wrong");
   chk_nor_none: assert property (scan_en |=> gate_o.nor_q ==
      !(|$past(gate_i.nor8))) else $error("NOR wrong");
   chk_orr_rise: assert property (scan_en |=> gate_o.orr_q ==
      (|($past(gate_i.orr8) & ~$past(s_reg.prev_orr)))) else $error("rising OR wrong");
   chk_orf_fall: assert property (scan_en |=> gate_o.orf_q ==
      (|(~$past(gate_i.orf8) & $past(s_reg.prev_orf)))) else $error("falling OR wrong");
   chk_scan_hold: assert property (!scan_en |=> $stable(gate_o))
      else $error("gate output moved between scans");
   chk_prev_copy: assert property (scan_en |=> s_reg.prev_orr == $past(gate_i.orr8))
      else $error("previous copy not stored");
   chk_tick_gap: assert property (tick |=> !tick [*8])
      else $error("tick too frequent");
   chk_setp_range: assert property (s_reg.on_setp >= LGT_TW'(1)
      && s_reg.off_setp >= LGT_TW'(1)) else $error("setpoint below one tick");
   chk_on_clear: assert property (scan_en && !on_trg_i |=> on_run_o == '0)
      else $error("on-delay time not cleared");
   chk_on_reset: assert property (scan_en && on_rst_i |=> !on_q_o)
      else $error("on-delay reset ignored");
   chk_off_restart: assert property (scan_en && !off_trg_i && $past(off_trg_i, SCAN_CYC)
      && !off_rst_i |=> off_run_o == '0) else $error("off-delay restart");
   chk_off_retrig: assert property (scan_en && off_trg_i && !off_rst_i
      |=> off_q_o && off_run_o == '0) else $error("off-delay retrigger");
   chk_off_reset: assert property (scan_en && off_rst_i |=> !off_q_o)
      else $error("off-delay reset ignored");

   cov_andl_fire: cover property (gate_o.andl_q);
   cov_on_fire: cover property (!on_q_o ##1 on_q_o);
   cov_off_expire: cover property (off_q_o ##1 !off_q_o && !off_rst_i);
   cov_on_abort: cover property (on_run_o != '0 ##1 on_run_o == '0 && !on_q_o);
endmodule : lgt_blocks

// [lgt_blocks_tb_top.sv]
// lgt_blocks_tb_top: self-checking bench for the gate library and both delay timers
// assumes lgt_pkg is compiled first; the scan and tick counts are shrunk for simulation
`timescale 1ns/100ps
module lgt_blocks_tb_top;
   import lgt_pkg::*;
   // =========================================================
   // shortened timing: 4-cycle scan, 20-cycle tick (10 ms)
   localparam int TICK_SIM = 20;
   localparam int SCAN_SIM = 4;
   logic                 mclk_i    = 1'b0;
   logic                 rst_i     = 1'b1;
   lgt_gin_t             gate_i    = '0;
   lgt_gout_t            gate_o;
   logic                 on_trg_i  = 1'b0;
   logic                 on_rst_i  = 1'b0;
   lgt_tcfg_t            on_cfg_i  = '0;
   logic                 on_q_o;
   logic    [LGT_TW-1:0] on_run_o;
   logic                 off_trg_i = 1'b0;
   logic                 off_rst_i = 1'b0;
   lgt_tcfg_t            off_cfg_i = '0;
   logic                 off_q_o;
   logic    [LGT_TW-1:0] off_run_o;
   int                   n_errors    = 0;
   int                   comparisons = 0;
   // =========================================================
   // clock and design under test
   always #5 mclk_i = ~mclk_i;
   lgt_blocks #(.TICK_CYC(TICK_SIM), .SCAN_CYC(SCAN_SIM)) lgt_blocks_i (
      .mclk_i(mclk_i), .rst_i(rst_i), .gate_i(gate_i), .gate_o(gate_o),
      .on_trg_i(on_trg_i), .on_rst_i(on_rst_i), .on_cfg_i(on_cfg_i),
      .on_q_o(on_q_o), .on_run_o(on_run_o),
      .off_trg_i(off_trg_i), .off_rst_i(off_rst_i), .off_cfg_i(off_cfg_i),
      .off_q_o(off_q_o), .off_run_o(off_run_o));
   // =========================================================
   // shared helpers
   task report_and_stop;
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : report_and_stop
   // case equality so an unknown output never counts as a match
   task check(input logic [31:0] act, input logic [31:0] exp, input string what);
      comparisons++;
      if (act !== exp) begin
         n_errors++;
         $display("[FAIL] %0t %s got %0h want %0h", $time, what, act, exp);
      end
   endtask : check
   task cyc(input int n);
      repeat (n) @(negedge mclk_i);
   endtask : cyc
   // bounded wait for a timer output; n returns the cycles spent
   task wait_q(input bit off, input logic val, input int lim, output int n);
      n = 0;
      while ((off ? off_q_o : on_q_o) !== val && n < lim) begin
         @(negedge mclk_i);
         n++;
      end
      if ((off ? off_q_o : on_q_o) !== val) begin
         n_errors++;
         $display("[FAIL] %0t timer output wait ran out", $time);
         report_and_stop();
      end
   endtask : wait_q
   // same pattern on every eight-input gate; ten cycles spans two scans
   task put_all(input logic [7:0] p, input logic n1, input logic [1:0] x);
      gate_i.and8   = p;
      gate_i.andl8  = p;
      gate_i.or8    = p;
      gate_i.nand8  = p;
      gate_i.nandl8 = p;
      gate_i.nor8   = p;
      gate_i.orr8   = p;
      gate_i.orf8   = p;
      gate_i.not1   = n1;
      gate_i.xor2   = x;
   endtask : put_all
   // =========================================================
   // level gates across boundary patterns, edge blocks idle when nothing moves
   task test_level_gates;
      logic [7:0] pats [6];
      pats = '{8'h00, 8'hff, 8'h01, 8'h80, 8'h7f, 8'hfe};
      for (int i = 0; i < 6; i++) begin
         put_all(pats[i], i[0], i[1:0]);
         cyc(10);
         check(gate_o.and_q, &pats[i], "and");
         check(gate_o.or_q, |pats[i], "or");
         check(gate_o.nand_q, ~&pats[i], "nand");
         check(gate_o.nor_q, ~|pats[i], "nor");
         check(gate_o.not_q, !i[0], "not");
         check(gate_o.xor_q, i[0] ^ i[1], "xor");
         check({gate_o.andl_q, gate_o.nandl_q, gate_o.orr_q, gate_o.orf_q},
               4'h0, "edge idle");
      end
   endtask : test_level_gates
   // =========================================================
   // edge blocks: one pattern step, collect any pulse over three scans
   task edge_step(input logic [7:0] p, input logic [3:0] exp, input string what);
      logic [3:0] seen;
      seen = 4'h0;
      put_all(p, 1'b0, 2'h0);
      repeat (12) begin
         @(negedge mclk_i);
         seen = seen | {gate_o.andl_q, gate_o.nandl_q, gate_o.orr_q, gate_o.orf_q};
      end
      check(seen, exp, what);
   endtask : edge_step
   task test_edge_gates;
      put_all(8'h00, 1'b0, 2'h0);
      cyc(12);
      edge_step(8'hff, 4'ha, "all rise");
      edge_step(8'h7f, 4'h5, "one fall");
      edge_step(8'hff, 4'ha, "one rise to all");
      edge_step(8'h00, 4'h5, "all fall");
      edge_step(8'h01, 4'h2, "first rise");
      edge_step(8'h03, 4'h2, "second rise");
      edge_step(8'h02, 4'h1, "partial fall");
      edge_step(8'h02, 4'h0, "no change");
   endtask : test_edge_gates
   // =========================================================
   // on-delay: 1 s 10 ms setpoint is 101 ticks, 2020 cycles here
   task test_on_delay;
      int n;
      on_cfg_i.setp = '{hours: 10'h000, minutes: 6'h00, seconds: 6'h01, millis: 10'h00a};
      cyc(4);
      on_trg_i = 1'b1;
      wait_q(1'b0, 1'b1, 2200, n);
      check(n >= 2000 && n <= 2060, 1'b1, "on-delay expiry");
      check(on_run_o, 29'd101, "on-delay held time");
      on_trg_i = 1'b0;
      wait_q(1'b0, 1'b0, 8, n);
      cyc(4);
      check(on_run_o, 29'd0, "on-delay cleared");
      // drop the trigger after 60 cycles, well short of the setpoint: time must not carry over
      on_trg_i = 1'b1;
      cyc(60);
      check(on_run_o >= 29'd1, 1'b1, "on-delay running");
      on_trg_i = 1'b0;
      cyc(8);
      check(on_run_o, 29'd0, "on-delay abort time");
      check(on_q_o, 1'b0, "on-delay abort out");
      // reset held through a rise: no timing at all
      on_rst_i = 1'b1;
      cyc(4);
      on_trg_i = 1'b1;
      cyc(200);
      check(on_q_o, 1'b0, "on-delay reset out");
      check(on_run_o, 29'd0, "on-delay reset time");
      on_trg_i = 1'b0;
      on_rst_i = 1'b0;
      cyc(8);
   endtask : test_on_delay
   // =========================================================
   // off-delay: 40 ms setpoint is 4 ticks, 80 cycles here
   task test_off_delay;
      int n;
      off_cfg_i.setp = '{hours: 10'h000, minutes: 6'h00, seconds: 6'h00, millis: 10'h028};
      cyc(4);
      off_trg_i = 1'b1;
      wait_q(1'b1, 1'b1, 8, n);
      check(off_run_o, 29'd0, "off-delay idle time");
      off_trg_i = 1'b0;
      wait_q(1'b1, 1'b0, 200, n);
      check(n >= 65 && n <= 100, 1'b1, "off-delay expiry");
      check(off_run_o, 29'd0, "off-delay cleared");
      // trigger back mid-timing, then a fresh fall must start from zero
      off_trg_i = 1'b1;
      cyc(8);
      off_trg_i = 1'b0;
      cyc(50);
      off_trg_i = 1'b1;
      cyc(8);
      check(off_q_o, 1'b1, "off-delay held out");
      check(off_run_o, 29'd0, "off-delay stopped");
      off_trg_i = 1'b0;
      cyc(50);
      check(off_q_o, 1'b1, "off-delay restart");
      wait_q(1'b1, 1'b0, 80, n);
      // reset wins against a high trigger
      off_trg_i = 1'b1;
      cyc(8);
      off_rst_i = 1'b1;
      wait_q(1'b1, 1'b0, 8, n);
      check(off_run_o, 29'd0, "off-delay reset time");
      off_trg_i = 1'b0;
      cyc(8);
      off_rst_i = 1'b0;
      cyc(8);
   endtask : test_off_delay
   // =========================================================
   // warm reset in mid-run: a retentive on-delay keeps its state, a plain off-delay clears
   task test_retain;
      on_cfg_i.retain = 1'b1;
      on_cfg_i.setp   = '{hours: 10'h000, minutes: 6'h00, seconds: 6'h00, millis: 10'h028};
      off_trg_i = 1'b1;
      cyc(4);
      on_trg_i = 1'b1;
      cyc(120);
      check(on_q_o, 1'b1, "on-delay before warm reset");
      rst_i = 1'b1;
      cyc(10);
      rst_i = 1'b0;
      cyc(2);
      check(on_q_o, 1'b1, "retained output");
      check(on_run_o, 29'd4, "retained time");
      check(off_q_o, 1'b0, "plain timer cleared");
      check(off_run_o, 29'd0, "plain timer time");
      on_trg_i  = 1'b0;
      off_trg_i = 1'b0;
      cyc(8);
      check(on_q_o, 1'b0, "on-delay low after warm reset");
      on_cfg_i.retain = 1'b0;
   endtask : test_retain
   // =========================================================
   // main sequence: inputs move only on falling edges
   initial begin
      cyc(10);
      rst_i = 1'b0;
      cyc(2);
      test_level_gates();
      test_edge_gates();
      test_on_delay();
      test_off_delay();
      test_retain();
      report_and_stop();
   end
endmodule : lgt_blocks_tb_top

// [lgt_pkg.sv]
// lgt_pkg: shared constants and carrier types for the logic gate and delay timer blocks
// assumes one 100 MHz clock and a synchronous active-high reset
package lgt_pkg;
   // =========================================================
   // clock, scan and tick timing
   localparam int LGT_CLK_MHZ   = 100;
   localparam int LGT_TICK_MS   = 10;
   localparam int LGT_TICK_CYC  = LGT_TICK_MS * 1000 * LGT_CLK_MHZ;
   localparam int LGT_SCAN_US   = 1;
   localparam int LGT_SCAN_CYC  = LGT_SCAN_US * LGT_CLK_MHZ;
   // =========================================================
   // widths and setpoint limits
   localparam int LGT_IN_W      = 8;
   localparam int LGT_TW        = 29;
   localparam int LGT_HOUR_MAX  = 999;
   localparam int LGT_MIN_MAX   = 59;
   localparam int LGT_SEC_MAX   = 59;
   localparam int LGT_MS_MAX    = 990;
   localparam int LGT_MS_MIN    = 10;
   localparam int LGT_TICK_SEC  = 1000 / LGT_TICK_MS;
   localparam int LGT_TICK_MIN  = 60 * LGT_TICK_SEC;
   localparam int LGT_TICK_HOUR = 60 * LGT_TICK_MIN;
   localparam logic [LGT_IN_W-1:0] LGT_PREV_RST = 8'h00;
   // =========================================================
   // carrier types
   typedef struct packed {
      logic [9:0] hours;
      logic [5:0] minutes;
      logic [5:0] seconds;
      logic [9:0] millis;
   } lgt_setp_t;
   typedef struct packed {
      logic      retain;
      lgt_setp_t setp;
   } lgt_tcfg_t;
   typedef struct packed {
      logic [LGT_IN_W-1:0] and8;
      logic [LGT_IN_W-1:0] andl8;
      logic [LGT_IN_W-1:0] or8;
      logic [LGT_IN_W-1:0] nand8;
      logic [LGT_IN_W-1:0] nandl8;
      logic [LGT_IN_W-1:0] nor8;
      logic [LGT_IN_W-1:0] orr8;
      logic [LGT_IN_W-1:0] orf8;
      logic                not1;
      logic [1:0]          xor2;
   } lgt_gin_t;
   typedef struct packed {
      logic and_q;
      logic andl_q;
      logic or_q;
      logic nand_q;
      logic nandl_q;
      logic nor_q;
      logic orr_q;
      logic orf_q;
      logic not_q;
      logic xor_q;
   } lgt_gout_t;
endpackage : lgt_pkg

// [lgt_timer.sv]
// lgt_timer: one delay timer, on-delay or off-delay by parameter
// assumes scan and tick enables from the parent and a setpoint already in ticks
`timescale 1ns/100ps
module lgt_timer #(
   parameter bit OFF_DELAY = 1'b0
) (
   input  wire logic                      mclk_i,    // system clock
   input  wire logic                      rst_i,     // global reset
   input  wire logic                      scan_en_i, // scan strobe
   input  wire logic                      tick_i,    // 10 ms tick
   input  wire logic                      half_i,    // tick phase past half
   input  wire logic                      trg_i,     // trigger
   input  wire logic                      trst_i,    // timer reset
   input  wire logic                      retain_i,  // retentive mode
   input  wire logic [lgt_pkg::LGT_TW-1:0] setp_i,   // setpoint in ticks
   output logic                           q_o,       // timer output
   output logic      [lgt_pkg::LGT_TW-1:0] run_o     // running value
);
   import lgt_pkg::*;
   typedef struct packed {
      logic              prev;
      logic              q;
      logic              running;
      logic              skip;
      logic              valid;
      logic [LGT_TW-1:0] elapsed;
   } lgt_tst_t;
   lgt_tst_t s_reg;
   lgt_tst_t s_next;
   logic     done;

   // =========================================================
   // next state
   assign done = s_reg.running && (s_reg.elapsed >= setp_i);
   always_comb begin
      s_next = s_reg;
      // skip absorbs a late-phase first tick so expiry lands within half a tick
      if (tick_i && s_reg.running && !done) begin
         if (s_reg.skip) begin
            s_next.skip = 1'b0;
         end else begin
            s_next.elapsed = s_reg.elapsed + 1'b1;
         end
      end
      if (scan_en_i) begin
         s_next.prev = trg_i;
         if (trst_i) begin
            s_next.q       = 1'b0;
            s_next.running = 1'b0;
            s_next.elapsed = '0;
         end else if (!OFF_DELAY) begin
            if (!trg_i) begin
               s_next.q       = 1'b0;
               s_next.running = 1'b0;
               s_next.elapsed = '0;
            end else if (!s_reg.prev) begin
               s_next.running = 1'b1;
               s_next.elapsed = '0;
               s_next.skip    = half_i;
            end else if (done) begin
               s_next.q       = 1'b1;
               s_next.running = 1'b0;
            end
         end else begin
            if (trg_i) begin
               s_next.q       = 1'b1;
               s_next.running = 1'b0;
               s_next.elapsed = '0;
            end else if (s_reg.prev) begin
               s_next.running = 1'b1;
               s_next.elapsed = '0;
               s_next.skip    = half_i;
            end else if (done) begin
               s_next.q       = 1'b0;
               s_next.running = 1'b0;
               s_next.elapsed = '0;
            end
         end
      end
   end

   // =========================================================
   // state register; a retained timer survives a warm reset
   always_ff @(posedge mclk_i) begin
      if (rst_i && !(retain_i && s_reg.valid)) begin
         s_reg <= '0;
      end else if (rst_i) begin
         s_reg <= s_reg;
      end else begin
         s_reg <= s_next;
         s_reg.valid <= 1'b1;
      end
   end
   assign q_o   = s_reg.q;
   assign run_o = s_reg.elapsed;

   // =========================================================
   // checks
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   chk_reset_wins: assert property (scan_en_i && trst_i |=> !q_o && run_o == '0)
      else $error("timer reset did not clear");
   // checked while reset is high: a retained timer must come through it untouched
   chk_retain_hold: assert property (disable iff (1'b0) rst_i && retain_i && s_reg.valid
      |=> q_o == $past(q_o) && run_o == $past(run_o)) else $error("retained state lost");
   chk_run_bound: assert property (run_o <= setp_i || !s_reg.running)
      else $error("elapsed passed setpoint");
   if (!OFF_DELAY) begin : g_on
      chk_on_low: assert property (scan_en_i && !trg_i |=> !q_o && run_o == '0)
         else $error("on-delay not cleared by low trigger");
      chk_on_fire: assert property (scan_en_i && trg_i && s_reg.prev && done && !trst_i
         |=> q_o) else $error("on-delay did not fire");
   end else begin : g_off
      chk_off_high: assert property (scan_en_i && trg_i && !trst_i |=> q_o)
         else $error("off-delay not high with trigger");
      chk_off_expire: assert property (scan_en_i && !trg_i && !s_reg.prev && done
         && !trst_i |=> !q_o && run_o == '0) else $error("off-delay expiry");
   end
endmodule : lgt_timer
